/* color_pixel_output_formatter_tb.sv */
// Purpose: self-checking bench for the pixel formatter
// Assumes: gray single-pixel frames give neutral chroma
// Notes:   rows cover formats and mosaic phases
`timescale 1ns/1ps
module color_pixel_output_formatter_tb;
  import cpof_pkg::*;
  typedef struct packed {
    cpof_fmt_t   f;
    logic        gf;
    logic        rr;
    logic [11:0] s;
    logic [23:0] d;
    cpof_ch_t    c;
  } cpof_row_t;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  cpof_fmt_t   fmt_sel_i = CPOF_FMT_RAW8;
  logic        g_first = 1'b0;
  logic        r_row = 1'b0;
  cpof_in_t    pix_i = '0;
  cpof_out_t   pix_o;
  int unsigned words;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          sent = 0;
  cpof_row_t   rows [5];
  always #20 ref_clk_i = ~ref_clk_i;
  cpof_formatter #(.LINE_MAX(8)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .fmt_sel_i(fmt_sel_i), .proc_raw_en_i(1'b0), .mosaic_g_first_i(g_first),
    .mosaic_r_row_i(r_row), .pix_i(pix_i), .pix_o(pix_o));
  cpof_host_sink u_sink (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pix_i(pix_o),
    .words_o(words));
  task automatic px(input cpof_fmt_t f, input logic [11:0] s, input logic v, input logic so,
                    input logic eo);
    @(posedge ref_clk_i);
    fmt_sel_i <= f;
    pix_i <= '{valid: v, sof: so, eol: eo, sample: s};
    sent += v;
  endtask
  task automatic ck(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    rows[0] = '{CPOF_FMT_RAW8, 1'b1, 1'b1, 12'hab5, 24'h0000ab, CPOF_CH_GREEN};
    rows[1] = '{CPOF_FMT_RAW12, 1'b0, 1'b1, 12'hab5, 24'h000ab5, CPOF_CH_RED};
    rows[2] = '{CPOF_FMT_RAW12, 1'b0, 1'b0, 12'h001, 24'h000001, CPOF_CH_BLUE};
    rows[3] = '{CPOF_FMT_YCC, 1'b0, 1'b1, 12'h7f0, 24'h80807f, CPOF_CH_RED};
    rows[4] = '{CPOF_FMT_LUMA8, 1'b1, 1'b0, 12'hc30, 24'h0000c3, CPOF_CH_GREEN};
    @(posedge ref_clk_i);
    #1 ck(pix_o === '0, "output not cleared in reset");
    @(posedge ref_clk_i) rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    foreach (rows[i]) begin
      px(rows[i].f, rows[i].s, 1'b1, 1'b1, 1'b1);
      g_first <= rows[i].gf;
      r_row <= rows[i].rr;
      px(rows[i].f, 12'h000, 1'b0, 1'b0, 1'b0);
      #1 ck(pix_o.data === rows[i].d && pix_o.fmt === rows[i].f, "row word");
      ck(pix_o.chan === rows[i].c && pix_o.sof === 1'b1 && pix_o.eol === 1'b1, "tags");
    end
    px(CPOF_FMT_RAW12, 12'h123, 1'b1, 1'b1, 1'b0);
    px(CPOF_FMT_RAW8, 12'h456, 1'b1, 1'b0, 1'b0);
    #1 ck(pix_o.data === 24'h000123, "first word");
    px(CPOF_FMT_RAW8, 12'h789, 1'b1, 1'b0, 1'b1);
    #1 ck(pix_o.data === 24'h000456 && pix_o.fmt === CPOF_FMT_RAW12, "mid-frame format");
    px(CPOF_FMT_RAW8, 12'h000, 1'b0, 1'b0, 1'b0);
    #1 ck(pix_o.data === 24'h000789 && pix_o.eol === 1'b1, "last word");
    px(CPOF_FMT_LUMA8, 12'h000, 1'b1, 1'b1, 1'b0);
    px(CPOF_FMT_LUMA8, 12'hfff, 1'b1, 1'b0, 1'b1);
    px(CPOF_FMT_LUMA8, 12'h000, 1'b0, 1'b0, 1'b0);
    #1 ck(pix_o.valid === 1'b1 && pix_o.data === 24'h000067, "luma from neighbours");
    ck(pix_o.chan === CPOF_CH_BLUE && pix_o.fmt === CPOF_FMT_LUMA8, "odd column tag");
    @(posedge ref_clk_i);
    #1 ck(words === sent, "word count");
    px(CPOF_FMT_RAW12, 12'hfff, 1'b1, 1'b1, 1'b1);
    rst_n_i <= 1'b0;
    #1 ck(pix_o === '0, "reset mid-frame");
    px(CPOF_FMT_RAW12, 12'h000, 1'b0, 1'b0, 1'b0);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    px(CPOF_FMT_RAW12, 12'hab5, 1'b1, 1'b0, 1'b0);
    px(CPOF_FMT_RAW12, 12'h000, 1'b0, 1'b0, 1'b0);
    #1 ck(pix_o.fmt === CPOF_FMT_RAW8 && pix_o.data === 24'h0000ab, "format after reset");
    results();
  end
endmodule // color_pixel_output_formatter_tb
bind cpof_formatter cpof_formatter_sva #(.LINE_MAX(LINE_MAX)) u_sva (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .fmt_sel_i(fmt_sel_i), .pix_i(pix_i), .pix_o(pix_o));

/* cpof_formatter.sv */
// Purpose: formats mosaic sensor samples into the selected pixel format
// Assumes: samples arrive in readout order, one per valid cycle
// Notes:   chroma uses a 2x2 mosaic neighbourhood; first line uses itself
//
// Functional notes
// - output layout follows selected pixel format
// - raw formats pass samples unprocessed, 8/12 bits
// - raw sample tagged with its filter colour
// - luma/chroma formats convert to Y, Cb, Cr
// - chroma offset by 128 to unsigned
// - mono format sends only 8-bit luma
// - luma uses pixel plus neighbouring pixels
// - raw without processed-raw bypasses colour stages; code bypasses them with processed raw enabled too
`timescale 1ns/1ps
module cpof_formatter #(
  parameter int LINE_MAX = 4096
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire cpof_pkg::cpof_fmt_t fmt_sel_i,
  input  wire logic               proc_raw_en_i,
  input  wire logic               mosaic_g_first_i,
  input  wire logic               mosaic_r_row_i,
  input  wire cpof_pkg::cpof_in_t pix_i,
  output cpof_pkg::cpof_out_t     pix_o
);
  import cpof_pkg::*;

  // line store must hold at least one quad column pair
  if (LINE_MAX < 2 || LINE_MAX > 65536) begin : g_line_max_bad
    $error("cpof_formatter: LINE_MAX out of range");
  end

  localparam int AW = $clog2(LINE_MAX);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] sat8(input logic signed [15:0] v);
    if (v < 0) begin
      sat8 = 8'h00;
    end else if (v > 16'sd255) begin
      sat8 = BYTE_MAX;
    end else begin
      sat8 = v[7:0];
    end
  endfunction

  function automatic cpof_ch_t site_ch(input logic odd_col, input logic odd_row,
                                       input logic g_first, input logic r_row);
    logic green;
    logic red_line;
    green    = odd_col ^ odd_row ^ g_first;
    red_line = odd_row ^ r_row;
    if (green) begin
      site_ch = CPOF_CH_GREEN;
    end else if (red_line) begin
      site_ch = CPOF_CH_RED;
    end else begin
      site_ch = CPOF_CH_BLUE;
    end
  endfunction

  // ****************************************************************
  // frame-aligned format latch and position
  // ****************************************************************
  cpof_fmt_t fmt_r;
  logic      proc_r;
  logic      gf_r;
  logic      rr_r;
  cpof_fmt_t fmt_act;
  logic      gf_act;
  logic      rr_act;
  always_comb begin
    fmt_act = (pix_i.valid && pix_i.sof) ? fmt_sel_i : fmt_r;
    gf_act  = (pix_i.valid && pix_i.sof) ? mosaic_g_first_i : gf_r;
    rr_act  = (pix_i.valid && pix_i.sof) ? mosaic_r_row_i : rr_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fmt_r  <= FMT_RST;
      proc_r <= 1'b0;
      gf_r   <= 1'b0;
      rr_r   <= 1'b0;
    end else if (pix_i.valid && pix_i.sof) begin
      fmt_r  <= fmt_sel_i;
      proc_r <= proc_raw_en_i;
      gf_r   <= mosaic_g_first_i;
      rr_r   <= mosaic_r_row_i;
    end
  end

  logic [AW-1:0] col_r;
  logic          row_odd_r;
  logic          first_row_r;
  logic [AW-1:0] col_act;
  logic          row_act;
  logic          frow_act;
  always_comb begin
    col_act  = (pix_i.valid && pix_i.sof) ? '0 : col_r;
    row_act  = (pix_i.valid && pix_i.sof) ? 1'b0 : row_odd_r;
    frow_act = (pix_i.valid && pix_i.sof) ? 1'b1 : first_row_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      col_r       <= '0;
      row_odd_r   <= 1'b0;
      first_row_r <= 1'b1;
    end else if (pix_i.valid) begin
      if (pix_i.eol) begin
        col_r       <= '0;
        row_odd_r   <= ~row_act;
        first_row_r <= 1'b0;
      end else begin
        col_r       <= col_act + AW'(1);
        row_odd_r   <= row_act;
        first_row_r <= frow_act;
      end
    end
  end

  // ****************************************************************
  // neighbourhood: previous line store and previous samples
  // ****************************************************************
  logic [SAMPLE_W-1:0] line_mem [LINE_MAX];
  logic [SAMPLE_W-1:0] up_cur;
  logic [SAMPLE_W-1:0] left_r;
  logic [SAMPLE_W-1:0] upleft_r;
  assign up_cur = line_mem[col_act];

  always_ff @(posedge ref_clk_i) begin
    if (pix_i.valid) begin
      line_mem[col_act] <= pix_i.sample;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      left_r   <= '0;
      upleft_r <= '0;
    end else if (pix_i.valid) begin
      left_r   <= pix_i.sample;
      upleft_r <= up_cur;
    end
  end

  // ****************************************************************
  // 2x2 quad to R, G, B then Y, Cb, Cr
  // ****************************************************************
  cpof_ch_t ch_cur;
  logic     odd_c;
  logic [SAMPLE_W-1:0] s_a;
  logic [SAMPLE_W-1:0] s_b;
  logic [SAMPLE_W-1:0] s_c;
  logic [SAMPLE_W-1:0] s_d;
  logic [7:0]  r8;
  logic [7:0]  g8;
  logic [7:0]  b8;
  logic [8:0]  gsum;
  logic signed [15:0] y_acc;
  logic signed [15:0] cb_acc;
  logic signed [15:0] cr_acc;
  logic [7:0]  y8;
  logic [7:0]  cb8;
  logic [7:0]  cr8;

  always_comb begin
    odd_c  = col_act[0];
    ch_cur = site_ch(odd_c, row_act, gf_act, rr_act);
    s_a = pix_i.sample;
    s_b = (col_act == '0) ? pix_i.sample : left_r;
    s_c = frow_act ? s_a : up_cur;
    s_d = frow_act ? s_b : ((col_act == '0) ? up_cur : upleft_r);
    r8 = 8'h00;
    b8 = 8'h00;
    gsum = 9'h000;
    if (ch_cur == CPOF_CH_GREEN) begin
      gsum = {1'b0, s_a[11:4]} + {1'b0, s_d[11:4]};
      if (site_ch(~odd_c, row_act, gf_act, rr_act) == CPOF_CH_RED) begin
        r8 = s_b[11:4];
        b8 = s_c[11:4];
      end else begin
        r8 = s_c[11:4];
        b8 = s_b[11:4];
      end
    end else begin
      gsum = {1'b0, s_b[11:4]} + {1'b0, s_c[11:4]};
      if (ch_cur == CPOF_CH_RED) begin
        r8 = s_a[11:4];
        b8 = s_d[11:4];
      end else begin
        r8 = s_d[11:4];
        b8 = s_a[11:4];
      end
    end
    g8 = gsum[8:1];
    // fixed-point /256 conversion; luma sum needs more than 16 bits
    y_acc  = 16'((77 * int'(r8) + 150 * int'(g8) + 29 * int'(b8)) >>> 8);
    cb_acc = ((16'sd128 * $signed({8'h00, b8}) - 16'sd43 * $signed({8'h00, r8})
             - 16'sd85 * $signed({8'h00, g8})) >>> 8)
             + $signed({7'h00, CHROMA_OFS});
    cr_acc = ((16'sd128 * $signed({8'h00, r8}) - 16'sd107 * $signed({8'h00, g8})
             - 16'sd21 * $signed({8'h00, b8})) >>> 8)
             + $signed({7'h00, CHROMA_OFS});
    y8  = sat8(y_acc);
    cb8 = sat8(cb_acc);
    cr8 = sat8(cr_acc);
  end

  // ****************************************************************
  // output word assembly
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pix_o <= '0;
    end else begin
      pix_o.valid <= pix_i.valid;
      pix_o.sof   <= pix_i.valid & pix_i.sof;
      pix_o.eol   <= pix_i.valid & pix_i.eol;
      pix_o.chan  <= ch_cur;
      pix_o.fmt   <= fmt_act;
      // raw paths never touch the colour stages, even with processed raw enabled
      if (!pix_i.valid) begin
        pix_o.data <= '0;
      end else begin
        case (fmt_act)
          CPOF_FMT_RAW8:  pix_o.data <= {16'h0000, pix_i.sample[11:4]};
          CPOF_FMT_RAW12: pix_o.data <= {12'h000, pix_i.sample};
          CPOF_FMT_YCC:   pix_o.data <= {cr8, cb8, y8};
          CPOF_FMT_LUMA8: pix_o.data <= {16'h0000, y8};
          default:        pix_o.data <= '0;
        endcase
      end
    end
  end

  logic unused_proc;
  assign unused_proc = proc_r;

endmodule // cpof_formatter

/* cpof_formatter_sva.sv */
// Purpose: port assertions for the formatter
// Assumes: fixed one-cycle latency
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module cpof_formatter_sva #(
  parameter int LINE_MAX = 4096
) (
  input wire logic                ref_clk_i,
  input wire logic                rst_n_i,
  input wire cpof_pkg::cpof_fmt_t fmt_sel_i,
  input wire cpof_pkg::cpof_in_t  pix_i,
  input wire cpof_pkg::cpof_out_t pix_o
);
  import cpof_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence mid_word;
    pix_o.valid && !pix_o.sof;
  endsequence
  word_latency_a: assert property (pix_i.valid |=> pix_o.valid)
    else $error("missing output word");
  no_spurious_a: assert property (!pix_i.valid |=> !pix_o.valid)
    else $error("output word without input");
  raw8_data_a: assert property (pix_o.valid && pix_o.fmt == CPOF_FMT_RAW8
    |-> pix_o.data == {16'h0000, $past(pix_i.sample[11:4])}) else $error("bad 8-bit raw");
  raw12_data_a: assert property (pix_o.valid && pix_o.fmt == CPOF_FMT_RAW12
    |-> pix_o.data == {12'h000, $past(pix_i.sample)}) else $error("bad 12-bit raw");
  luma_only_a: assert property (pix_o.fmt == CPOF_FMT_LUMA8
    |-> pix_o.data[23:8] == 16'h0000) else $error("mono word carries chroma");
  sof_fmt_a: assert property (pix_i.valid && pix_i.sof
    |=> pix_o.sof && pix_o.fmt == $past(fmt_sel_i)) else $error("format not taken at sof");
  eol_pass_a: assert property (pix_i.valid |=> pix_o.eol == $past(pix_i.eol))
    else $error("line end lost");
  idle_zero_a: assert property (!pix_o.valid |-> pix_o.data == 24'h000000)
    else $error("idle data not zero");
  fmt_hold_a: assert property (mid_word ##1 mid_word |-> $stable(pix_o.fmt))
    else $error("format changed inside frame");
endmodule // cpof_formatter_sva

/* cpof_host_sink.sv */
// Purpose: host-side sink counting formatted words
// Assumes: one word per valid cycle
// Notes:   takes every word, no back-pressure
`timescale 1ns/1ps
module cpof_host_sink (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire cpof_pkg::cpof_out_t pix_i,
  output int unsigned              words_o
);
  import cpof_pkg::*;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      words_o <= 0;
    end else if (pix_i.valid) begin
      words_o <= words_o + 1;
    end
  end
endmodule // cpof_host_sink

/* cpof_pkg.sv */
// Purpose: shared types and constants for the color pixel output formatter
// Assumes: one pixel clock, mosaic sensor samples of 12 bits
// Notes:   format codes are internal selections, not register values
package cpof_pkg;

  // ****************************************************************
  // widths and constants
  // ****************************************************************
  localparam int        SAMPLE_W    = 12;
  localparam int        OUT_W       = 24;
  localparam logic [8:0] CHROMA_OFS = 9'h080;
  localparam logic [7:0] BYTE_MAX   = 8'hff;
  localparam logic [1:0] PHASE_RST  = 2'h0;

  // ****************************************************************
  // pixel format selection
  // ****************************************************************
  typedef enum logic [2:0] {
    CPOF_FMT_RAW8  = 3'h0,
    CPOF_FMT_RAW12 = 3'h1,
    CPOF_FMT_YCC   = 3'h2,
    CPOF_FMT_LUMA8 = 3'h3
  } cpof_fmt_t;

  localparam cpof_fmt_t FMT_RST = CPOF_FMT_RAW8;

  // mosaic filter colour of a site
  typedef enum logic [1:0] {
    CPOF_CH_RED   = 2'h0,
    CPOF_CH_GREEN = 2'h1,
    CPOF_CH_BLUE  = 2'h2
  } cpof_ch_t;

  // ****************************************************************
  // stream carriers
  // ****************************************************************
  typedef struct packed {
    logic                valid;
    logic                sof;
    logic                eol;
    logic [SAMPLE_W-1:0] sample;
  } cpof_in_t;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             eol;
    cpof_ch_t         chan;
    cpof_fmt_t        fmt;
    logic [OUT_W-1:0] data;
  } cpof_out_t;

endpackage
